// >>> core/tw_map.vh
/*
 * Register map, field positions, status codes and timing figures of the
 * two-wire master transmitter.
 * Assumes it is included by its bare name from the core/ design files.
 */
`ifndef TW_MAP_VH
`define TW_MAP_VH

// Register indices on the 2-bit address port.
`define TW_ADDR_CTRL 2'h0
`define TW_ADDR_STATUS 2'h1
`define TW_ADDR_DATA 2'h2
`define TW_ADDR_MODE 2'h3

// Control register bit positions.
`define TW_B_FLAG 7
`define TW_B_ACKEN 6
`define TW_B_STA 5
`define TW_B_STO 4
`define TW_B_WC 3
`define TW_B_EN 2
`define TW_B_IE 0

// Reset values.
`define TW_CTRL_RST 8'h00
`define TW_STATUS_RST 8'hF8
`define TW_DATA_RST 8'hFF

// Status codes, prescaler bits masked to zero.
`define TW_ST_START 8'h08
`define TW_ST_RSTART 8'h10
`define TW_ST_SLAW_ACK 8'h18
`define TW_ST_SLAW_NACK 8'h20
`define TW_ST_DATA_ACK 8'h28
`define TW_ST_DATA_NACK 8'h30
`define TW_ST_ARB_LOST 8'h38
`define TW_ST_SLAR_ACK 8'h40
`define TW_ST_SLAR_NACK 8'h48
`define TW_STATUS_MASK 8'hF8

// Bits per byte, index of the acknowledge slot.
`define TW_ACK_SLOT 4'h8

// Serial clock period and system clock period in nanoseconds.
`define TW_SCL_PERIOD_NS 800
`define TW_SYS_PERIOD_NS 100
// Quarter of a serial bit in system cycles, never below one.
`define TW_QUARTER_CYC (((`TW_SCL_PERIOD_NS / 4) / `TW_SYS_PERIOD_NS) < 1 ? 1 : \
  ((`TW_SCL_PERIOD_NS / 4) / `TW_SYS_PERIOD_NS))

`endif

// >>> core/tw_sync.v
/*
 * Two-flop synchroniser for pin levels.
 * Assumes d_i comes from outside the system clock domain.
 */
module tw_sync #(
  parameter WIDTH = 2
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire [WIDTH-1:0] d_i,
  output reg [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta;

  // First stage feeds only the second; idle bus lines reset high.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta <= {WIDTH{1'b1}};
      q_o <= {WIDTH{1'b1}};
    end else if (ce_i) begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // tw_sync

// >>> core/tw_tick.v
/*
 * Quarter-bit tick generator for the serial clock.
 * Assumes run_i stays high while a bus sequence is in progress.
 */
module tw_tick #(
  parameter QUARTER = 2,
  parameter CW = 8
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire run_i,
  output wire tick_o
);
  reg [CW-1:0] cnt;
  // The count limit is cut to the counter width on purpose.
  localparam integer LAST_I = QUARTER - 1;
  localparam [CW-1:0] LAST = LAST_I[CW-1:0];

  // Counts system cycles and restarts whenever the engine stops.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt <= {CW{1'b0}};
    end else if (ce_i) begin
      if (!run_i || cnt == LAST) begin
        cnt <= {CW{1'b0}};
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  assign tick_o = run_i && (cnt == LAST);
endmodule // tw_tick

// >>> core/tw_master.v
/*
 * Two-wire master transmitter: control, status, data and mode registers,
 * START / repeated START / STOP generation, byte shifting with acknowledge,
 * write-collision detection and arbitration-loss handling.
 * Assumes a simple register port (read data one cycle after the strobe) and
 * open-drain SCL/SDA pads resolved outside; pad inputs are asynchronous.
 */
// The register offsets and the address-and-strobe port were chosen for this implementation.
`include "tw_map.vh"

module tw_master #(
  parameter QUARTER_CYC = `TW_QUARTER_CYC
) (
  input wire CLK_SYS_I,
  input wire RST_N_I,
  input wire CE_I,
  input wire [1:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [7:0] RDATA_O,
  input wire SCL_I,
  output wire SCL_O,
  output wire SCL_OE_N_O,
  input wire SDA_I,
  output wire SDA_O,
  output wire SDA_OE_N_O,
  output wire IRQ_O
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WAIT_FREE = 3'h1;
  localparam [2:0] ST_START = 3'h2;
  localparam [2:0] ST_HOLD = 3'h3;
  localparam [2:0] ST_BYTE = 3'h4;
  localparam [2:0] ST_STOP = 3'h5;

  // Control fields.
  reg flag, ack_enable, start_request, stop_request;
  reg write_collision_flag, enable, irq_enable;
  // Status, data and engine state.
  reg [7:0] status_code;
  reg [1:0] prescale;
  reg [7:0] two_wire_data;
  reg [7:0] shift;
  reg [3:0] bit_cnt;
  reg [1:0] phase;
  reg [2:0] state;
  reg addr_phase, dir_read, nack, in_xfer, master_receive_mode;
  reg scl_pull, sda_pull, bus_busy, scl_q, sda_q;
  // Reset image of the control register, so single fields can be picked from it.
  localparam [7:0] CTRL_RST = `TW_CTRL_RST;

  wire scl_s, sda_s, tick, running, step;
  wire wr_ctrl, wr_data, wr_status, launch_clear;

  // Pad levels cross into the system clock domain.
  tw_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .d_i({SCL_I, SDA_I}),
    .q_o({scl_s, sda_s})
  );

  assign running = (state == ST_START) || (state == ST_BYTE) || (state == ST_STOP);

  // Quarter-bit timing for every bus sequence.
  tw_tick #(
    .QUARTER(QUARTER_CYC)
  ) u_tick (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .run_i(running),
    .tick_o(tick)
  );

  // A released SCL held low by a slave stretches the current quarter.
  assign step = tick && !(!scl_pull && !scl_s);

  // Register port decode.
  assign wr_ctrl = WR_I && (ADDR_I == `TW_ADDR_CTRL);
  assign wr_data = WR_I && (ADDR_I == `TW_ADDR_DATA);
  assign wr_status = WR_I && (ADDR_I == `TW_ADDR_STATUS);
  assign launch_clear = wr_ctrl && WDATA_I[`TW_B_FLAG] && WDATA_I[`TW_B_EN];

  // Open-drain pads: only ever pull low, enable active low.
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE_N_O = !scl_pull;
  assign SDA_OE_N_O = !sda_pull;
  assign IRQ_O = flag && irq_enable;

  // Bus-busy tracking from START and STOP seen on the synchronised lines.
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bus_busy <= 1'b0;
    end else if (CE_I) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      if (scl_s && scl_q && sda_q && !sda_s) begin
        bus_busy <= 1'b1;
      end else if (scl_s && scl_q && !sda_q && sda_s) begin
        bus_busy <= 1'b0;
      end
    end
  end

  // Register writes first, then the engine; a hardware set of the flag
  // comes later in the process so it wins over a clear in the same cycle.
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      flag <= CTRL_RST[`TW_B_FLAG];
      ack_enable <= 1'b0;
      start_request <= 1'b0;
      stop_request <= 1'b0;
      write_collision_flag <= 1'b0;
      enable <= 1'b0;
      irq_enable <= 1'b0;
      status_code <= `TW_STATUS_RST;
      prescale <= 2'h0;
      two_wire_data <= `TW_DATA_RST;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      phase <= 2'h0;
      state <= ST_IDLE;
      addr_phase <= 1'b0;
      dir_read <= 1'b0;
      nack <= 1'b0;
      in_xfer <= 1'b0;
      master_receive_mode <= 1'b0;
      scl_pull <= 1'b0;
      sda_pull <= 1'b0;
    end else if (CE_I) begin
      // Control register: flag clears when a one is written to it together with the enable bit, collision is read-only.
      if (wr_ctrl) begin
        ack_enable <= WDATA_I[`TW_B_ACKEN];
        start_request <= WDATA_I[`TW_B_STA];
        stop_request <= WDATA_I[`TW_B_STO];
        enable <= WDATA_I[`TW_B_EN];
        irq_enable <= WDATA_I[`TW_B_IE];
      end
      if (launch_clear) begin
        flag <= 1'b0;
      end
      if (wr_status) begin
        prescale <= WDATA_I[1:0];
      end
      // Data writes count only while the flag is high.
      if (wr_data) begin
        if (flag) begin
          two_wire_data <= WDATA_I;
          write_collision_flag <= 1'b0;
        end else begin
          write_collision_flag <= 1'b1;
        end
      end
      if (!enable) begin
        // Disabled interface: release the pads and forget the transfer.
        state <= ST_IDLE;
        scl_pull <= 1'b0;
        sda_pull <= 1'b0;
        in_xfer <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            scl_pull <= 1'b0;
            sda_pull <= 1'b0;
            if (start_request && !flag) begin
              state <= ST_WAIT_FREE;
            end
          end
          ST_WAIT_FREE: begin
            if (!bus_busy) begin
              state <= ST_START;
              phase <= 2'h0;
            end
          end
          ST_START: begin
            if (step) begin
              phase <= phase + 2'h1;
              case (phase)
                2'h0: sda_pull <= 1'b0;
                2'h1: scl_pull <= 1'b0;
                2'h2: begin
                  if (!sda_s) begin
                    // Another master owns SDA: give up the bus.
                    scl_pull <= 1'b0;
                    flag <= 1'b1;
                    status_code <= `TW_ST_ARB_LOST;
                    in_xfer <= 1'b0;
                    state <= ST_IDLE;
                  end else begin
                    sda_pull <= 1'b1;
                  end
                end
                default: begin
                  scl_pull <= 1'b1;
                  flag <= 1'b1;
                  status_code <= in_xfer ? `TW_ST_RSTART : `TW_ST_START;
                  in_xfer <= 1'b1;
                  addr_phase <= 1'b1;
                  master_receive_mode <= 1'b0;
                  state <= ST_HOLD;
                end
              endcase
            end
          end
          ST_HOLD: begin
            // SCL stays low until software clears the flag.
            if (!flag) begin
              phase <= 2'h0;
              if (stop_request) begin
                state <= ST_STOP;
              end else if (start_request) begin
                state <= ST_START;
              end else begin
                shift <= two_wire_data;
                dir_read <= addr_phase && two_wire_data[0];
                bit_cnt <= 4'h0;
                state <= ST_BYTE;
              end
            end
          end
          ST_BYTE: begin
            if (step) begin
              phase <= phase + 2'h1;
              case (phase)
                2'h0: begin
                  if (bit_cnt == `TW_ACK_SLOT) begin
                    sda_pull <= 1'b0;
                  end else begin
                    sda_pull <= !shift[7];
                  end
                end
                2'h1: scl_pull <= 1'b0;
                2'h2: begin
                  if (bit_cnt == `TW_ACK_SLOT) begin
                    nack <= sda_s;
                  end else if (!sda_pull && !sda_s) begin
                    scl_pull <= 1'b0;
                    flag <= 1'b1;
                    status_code <= `TW_ST_ARB_LOST;
                    in_xfer <= 1'b0;
                    state <= ST_IDLE;
                  end
                end
                default: begin
                  scl_pull <= 1'b1;
                  if (bit_cnt == `TW_ACK_SLOT) begin
                    flag <= 1'b1;
                    addr_phase <= 1'b0;
                    state <= ST_HOLD;
                    if (!addr_phase) begin
                      status_code <= nack ? `TW_ST_DATA_NACK : `TW_ST_DATA_ACK;
                    end else if (dir_read) begin
                      master_receive_mode <= 1'b1;
                      status_code <= nack ? `TW_ST_SLAR_NACK : `TW_ST_SLAR_ACK;
                    end else begin
                      status_code <= nack ? `TW_ST_SLAW_NACK : `TW_ST_SLAW_ACK;
                    end
                  end else begin
                    shift <= {shift[6:0], 1'b0};
                    bit_cnt <= bit_cnt + 4'h1;
                  end
                end
              endcase
            end
          end
          ST_STOP: begin
            if (step) begin
              phase <= phase + 2'h1;
              case (phase)
                2'h0: sda_pull <= 1'b1;
                2'h1: scl_pull <= 1'b0;
                2'h2: sda_pull <= 1'b0;
                default: begin
                  stop_request <= 1'b0;
                  in_xfer <= 1'b0;
                  master_receive_mode <= 1'b0;
                  state <= start_request ? ST_WAIT_FREE : ST_IDLE;
                end
              endcase
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Read data appear in the cycle after the read strobe, zero otherwise.
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 8'h00;
    end else if (CE_I) begin
      if (RD_I) begin
        case (ADDR_I)
          `TW_ADDR_CTRL: RDATA_O <= {flag, ack_enable, start_request, stop_request,
            write_collision_flag, enable, 1'b0, irq_enable};
          `TW_ADDR_STATUS: RDATA_O <= {status_code[7:3], 1'b0, prescale};
          `TW_ADDR_DATA: RDATA_O <= two_wire_data;
          default: RDATA_O <= {5'h00, state == ST_HOLD, in_xfer, master_receive_mode};
        endcase
      end else begin
        RDATA_O <= 8'h00;
      end
    end
  end
endmodule // tw_master

// >>> test/tw_checker.sv
/*
 * Assertion checker for the two-wire master transmitter.
 * Assumes it is bound to tw_master and sees only its ports.
 */
module tw_checker #(
  parameter QUARTER_CYC = 2
) (
  input wire CLK_SYS_I,
  input wire RST_N_I,
  input wire CE_I,
  input wire [1:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  input wire [7:0] RDATA_O,
  input wire SCL_OE_N_O,
  input wire SDA_OE_N_O,
  input wire IRQ_O
);
  logic ie_sh;
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_cnt;
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_N_I);
  // Shadows the interrupt enable so IRQ_O reveals the flag, and counts SCL releases.
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      ie_sh <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_cnt <= 4'h0;
    end else begin
      scl_q <= SCL_OE_N_O;
      sda_q <= SDA_OE_N_O;
      if (CE_I && WR_I && ADDR_I == 2'h0) ie_sh <= WDATA_I[0];
      if (sda_q && !SDA_OE_N_O && SCL_OE_N_O) bit_cnt <= 4'h0;
      else if (!scl_q && SCL_OE_N_O) bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
    end
  end
  sequence s_data_wr_flag;
    WR_I && CE_I && ADDR_I == 2'h2 && ie_sh && IRQ_O;
  endsequence
  sequence s_data_wr_idle;
    WR_I && CE_I && ADDR_I == 2'h2 && ie_sh && !IRQ_O;
  endsequence
  AST_RDATA_IDLE: assert property (!(RD_I && CE_I) |=> RDATA_O == 8'h00)
    else $error("read data not zero outside a read answer");
  AST_IRQ_MATCH: assert property ((RD_I && CE_I && ADDR_I == 2'h0) |=>
    (RDATA_O[7] && RDATA_O[0]) == $past(IRQ_O)) else $error("interrupt differs from flag and enable");
  AST_HOLD: assert property ((IRQ_O && CE_I && !WR_I && !$past(WR_I)) |=>
    $stable(SCL_OE_N_O) && $stable(SDA_OE_N_O)) else $error("bus moved while flag set");
  AST_DATA_RB: assert property (s_data_wr_flag ##1 !WR_I ##1 (RD_I && ADDR_I == 2'h2) |=>
    RDATA_O == $past(WDATA_I, 3)) else $error("data write with flag set was lost");
  AST_WC_SET: assert property (s_data_wr_idle ##1 !WR_I ##1 (RD_I && ADDR_I == 2'h0) |=>
    RDATA_O[3]) else $error("collision bit not set");
  AST_STOP_BUS: assert property ((WR_I && CE_I && ADDR_I == 2'h0 && WDATA_I[7:4] == 4'h9
    && WDATA_I[2] && IRQ_O) |-> ##[3:300] (SCL_OE_N_O && SDA_OE_N_O)) else $error("no stop");
  AST_START_FLAG: assert property (($fell(SDA_OE_N_O) && SCL_OE_N_O && ie_sh) |->
    ##[1:60] (!SCL_OE_N_O && IRQ_O)) else $error("flag not set after start");
  AST_ACK_SLOT: assert property (($rose(SCL_OE_N_O) && bit_cnt == 4'h8) |-> SDA_OE_N_O)
    else $error("data line not released in acknowledge slot");
endmodule // tw_checker

bind tw_master tw_checker #(.QUARTER_CYC(QUARTER_CYC)) u_chk (.CLK_SYS_I(CLK_SYS_I),
  .RST_N_I(RST_N_I), .CE_I(CE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .SCL_OE_N_O(SCL_OE_N_O), .SDA_OE_N_O(SDA_OE_N_O),
  .IRQ_O(IRQ_O));

// >>> test/tw_slave.sv
/*
 * Behavioural slave receiver on the two-wire bus.
 * Assumes open-drain lines with pull-ups, resolved by the bench.
 */
module tw_slave (
  input wire scl_i,
  input wire sda_i,
  input wire ack_i,
  output logic sda_oe_n_o,
  output logic [7:0] byte_o,
  output logic [3:0] nbits_o,
  output logic [7:0] nbytes_o,
  output logic stop_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic in_ack;
  logic scl_d;
  logic sda_d;
  // One process owns every output: it starts released, then follows both lines.
  initial begin
    in_ack = 1'b0;
    scl_d = 1'b1;
    sda_d = 1'b1;
    sda_oe_n_o = 1'b1;
    byte_o = 8'h00;
    nbits_o = 4'h0;
    nbytes_o = 8'h00;
    stop_o = 1'b0;
    forever begin
      @(scl_i or sda_i);
      if (scl_i === 1'b1 && scl_d === 1'b1 && sda_i !== sda_d) begin
        // SDA moving while SCL is high is a START when falling, a STOP when rising.
        if (sda_i === 1'b0) begin
          nbits_o = 4'h0;
          stop_o = 1'b0;
        end else begin
          stop_o = 1'b1;
        end
      end else if (scl_i === 1'b1 && scl_d !== 1'b1) begin
        // Data bits are taken most significant first at the SCL rise.
        if (nbits_o < 4'h8) begin
          byte_o = {byte_o[6:0], sda_i};
          nbits_o = nbits_o + 4'h1;
        end
      end else if (scl_i === 1'b0 && scl_d === 1'b1) begin
        // Acknowledge slot after eight bits, let go at the following SCL fall.
        if (in_ack) begin
          in_ack = 1'b0;
          sda_oe_n_o = 1'b1;
          nbits_o = 4'h0;
        end else if (nbits_o == 4'h8) begin
          in_ack = 1'b1;
          sda_oe_n_o = ~ack_i;
          nbytes_o = nbytes_o + 8'h01;
        end
      end
      scl_d = scl_i;
      sda_d = sda_i;
    end
  end
endmodule // tw_slave

// >>> test/tb_top.sv
/*
 * Self-checking bench for the two-wire master transmitter.
 * Assumes tw_master, tw_slave and the bound checker are compiled with it.
 */
`include "tw_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, wr_s, rd_s, ack, ce;
  logic [1:0] addr;
  logic [7:0] wdata;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  wire [7:0] rdata, s_byte, s_cnt;
  wire [3:0] s_bits;
  wire scl_o, scl_oe_n, sda_o, sda_oe_n, s_oe_n, irq, s_stop;
  wire scl = scl_oe_n | scl_o;
  wire sda = (sda_oe_n | sda_o) & s_oe_n;
  tw_master #(.QUARTER_CYC(2)) u_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
    .SCL_I(scl), .SCL_O(scl_o), .SCL_OE_N_O(scl_oe_n), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_N_O(sda_oe_n), .IRQ_O(irq));
  tw_slave u_slave (.scl_i(scl), .sda_i(sda), .ack_i(ack), .sda_oe_n_o(s_oe_n),
    .byte_o(s_byte), .nbits_o(s_bits), .nbytes_o(s_cnt), .stop_o(s_stop));
  // Clock and hang guard.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // Register writes and reads leave a quiet cycle so strobes never collide.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  // Issues a command, polls the flag and compares the masked status.
  task automatic step(input logic [7:0] c, input logic [7:0] exp);
    logic [7:0] v;
    v = 8'h00;
    wr(`TW_ADDR_CTRL, c);
    for (int i = 0; i < 200 && v[7] !== 1'b1; i++) rd(`TW_ADDR_CTRL, v);
    chk1(v[7], 1'b1);
    rd(`TW_ADDR_STATUS, v);
    chk8(v & `TW_STATUS_MASK, exp);
  endtask
  task automatic t_reset;
    logic [7:0] v;
    rd(`TW_ADDR_CTRL, v);
    chk8(v, `TW_CTRL_RST);
    rd(`TW_ADDR_STATUS, v);
    chk8(v, `TW_STATUS_RST);
    rd(`TW_ADDR_DATA, v);
    chk8(v, `TW_DATA_RST);
    // A command written while the clock enable is low must not land.
    ce <= 1'b0;
    wr(`TW_ADDR_CTRL, 8'hA5);
    ce <= 1'b1;
    rd(`TW_ADDR_CTRL, v);
    chk8(v, `TW_CTRL_RST);
    wr(`TW_ADDR_CTRL, 8'h01);
    wr(`TW_ADDR_DATA, 8'h3C);
    rd(`TW_ADDR_CTRL, v);
    chk8(v, 8'h09);
    rd(`TW_ADDR_DATA, v);
    chk8(v, `TW_DATA_RST);
    $display("t_reset done");
  endtask
  task automatic t_start_addr;
    logic [7:0] v;
    step(8'hA5, `TW_ST_START);
    chk1(irq, 1'b1);
    repeat (20) @(posedge clk);
    chk1(scl, 1'b0);
    chk8({4'h0, s_bits}, 8'h00);
    wr(`TW_ADDR_DATA, 8'hA0);
    rd(`TW_ADDR_DATA, v);
    chk8(v, 8'hA0);
    rd(`TW_ADDR_CTRL, v);
    chk1(v[3], 1'b0);
    step(8'h85, `TW_ST_SLAW_ACK);
    chk8(s_byte, 8'hA0);
    $display("t_start_addr done");
  endtask
  task automatic t_data;
    logic [7:0] d;
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 8'h5A : (i == 1) ? 8'h81 : 8'hC3;
      ack <= (i < 2);
      wr(`TW_ADDR_DATA, d);
      step(8'h85, (i < 2) ? `TW_ST_DATA_ACK : `TW_ST_DATA_NACK);
      chk8(s_byte, d);
    end
    $display("t_data done");
  endtask
  task automatic t_rstart_stop;
    logic [7:0] v;
    step(8'hA5, `TW_ST_RSTART);
    chk1(s_stop, 1'b0);
    ack <= 1'b0;
    wr(`TW_ADDR_DATA, 8'h42);
    step(8'h85, `TW_ST_SLAW_NACK);
    chk8(s_byte, 8'h42);
    wr(`TW_ADDR_CTRL, 8'h95);
    v = 8'h10;
    for (int i = 0; i < 100 && v[4] !== 1'b0; i++) rd(`TW_ADDR_CTRL, v);
    chk1(v[4], 1'b0);
    chk1(v[7], 1'b0);
    repeat (4) @(posedge clk);
    chk1(s_stop, 1'b1);
    chk1(irq, 1'b0);
    chk8(s_cnt, 8'h05);
    $display("t_rstart_stop done");
  endtask
  // Prescaler bits, an address with the read bit, and the mode register.
  task automatic t_read_addr;
    logic [7:0] v;
    wr(`TW_ADDR_STATUS, 8'h03);
    rd(`TW_ADDR_STATUS, v);
    chk8(v, `TW_ST_SLAW_NACK | 8'h03);
    ack <= 1'b1;
    step(8'hA5, `TW_ST_START);
    wr(`TW_ADDR_DATA, 8'hA1);
    step(8'h85, `TW_ST_SLAR_ACK);
    chk8(s_byte, 8'hA1);
    rd(`TW_ADDR_MODE, v);
    chk8(v, 8'h07);
    wr(`TW_ADDR_CTRL, 8'h95);
    repeat (60) @(posedge clk);
    chk1(s_stop, 1'b1);
    rd(`TW_ADDR_MODE, v);
    chk8(v, 8'h00);
    $display("t_read_addr done");
  endtask
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    ack = 1'b1;
    ce = 1'b1;
    addr = 2'h0;
    wdata = 8'h00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_start_addr();
    t_data();
    t_rstart_stop();
    t_read_addr();
    wrap_up();
  end
endmodule // tb_top
